/* logic/lsa_top.sv */
// Link status, CRC error counter and remote alias registers behind an AXI4-Lite slave.
`timescale 1ns/1ps
module lsa_top
    import lsa_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                link_detect_pin,
    input  wire logic                input_clock_present_pin,
    input  wire logic                link_loss_evt,
    input  wire logic                crc_err_evt,
    input  wire logic                selftest_active,
    input  wire logic                selftest_restart,
    input  wire logic                err_reset,
    input  lsa_i2c_req_t             i2c_req,
    output lsa_i2c_fwd_t             i2c_fwd,
    output logic                     irq
);

    function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[7:2];
    endfunction

    function automatic logic index_mapped(input logic [5:0] idx);
        index_mapped = (idx == IDX_TARGET) || (idx == IDX_ALIAS) ||
                       (idx == IDX_CRC_LO) || (idx == IDX_CRC_HI) ||
                       (idx == IDX_STATUS) || (idx == IDX_INT_STAT) ||
                       (idx == IDX_INT_MASK);
    endfunction

    // Pin inputs cross into aclk through two flip-flops.
    logic [1:0]        link_sync_r;
    logic [1:0]        clk_sync_r;

    logic [6:0]        alias_r;
    logic [6:0]        target_r;
    logic [15:0]       crc_cnt_r;
    lsa_status_t       status_r;
    logic [IRQ_W-1:0]  int_stat_r;
    logic [IRQ_W-1:0]  int_mask_r;
    logic              irq_r;
    lsa_i2c_fwd_t      fwd_r;

    logic              aw_held_r;
    logic              w_held_r;
    logic [5:0]        aw_idx_r;
    logic [DATA_W-1:0] wdata_r;
    logic [3:0]        wstrb_r;
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [DATA_W-1:0] rdata_r;
    logic [1:0]        rresp_r;

    // Write channel handshakes; address and data may arrive in either order.
    wire               aw_take     = s_axi_awvalid && awready_r;
    wire               w_take      = s_axi_wvalid && wready_r;
    wire               wr_fire     = aw_held_r && w_held_r && !bvalid_r;
    wire               aw_held_nxt = aw_held_r ? !wr_fire : aw_take;
    wire               w_held_nxt  = w_held_r ? !wr_fire : w_take;
    wire               b_done      = bvalid_r && s_axi_bready;
    wire               bvalid_nxt  = wr_fire || (bvalid_r && !s_axi_bready);
    wire               wr_lane0    = wr_fire && wstrb_r[0];
    wire               wr_mapped   = index_mapped(aw_idx_r);

    wire               wr_alias    = wr_lane0 && (aw_idx_r == IDX_ALIAS);
    wire               wr_target   = wr_lane0 && (aw_idx_r == IDX_TARGET);
    wire               wr_int_stat = wr_lane0 && (aw_idx_r == IDX_INT_STAT);
    wire               wr_int_mask = wr_lane0 && (aw_idx_r == IDX_INT_MASK);

    // Read channel: one read at a time, arready drops while the answer waits.
    wire               ar_take     = s_axi_arvalid && arready_r;
    wire               rvalid_nxt  = ar_take || (rvalid_r && !s_axi_rready);
    wire [5:0]         ar_idx      = reg_index(s_axi_araddr);
    wire               rd_mapped   = index_mapped(ar_idx);

    wire               link_now    = link_sync_r[1];
    wire               clk_now     = clk_sync_r[1];

    // Self-test and normal traffic errors are told apart by the self-test state.
    wire               st_crc_set  = crc_err_evt && selftest_active;
    wire               rem_crc_set = crc_err_evt && !selftest_active;

    // RULE3 RULE4 counter step.
    // The counter saturates so a long error burst never wraps back to a small value.
    wire [15:0]        crc_inc     = (crc_cnt_r == CRC_MAX) ? CRC_MAX : crc_cnt_r + 16'h0001;
    wire [15:0]        crc_cnt_nxt = crc_err_evt ? (err_reset ? 16'h0001 : crc_inc) :
                                     (err_reset ? CRC_RESET : crc_cnt_r);

    // RULE5 link lost flag.
    // A fresh loss in the clearing cycle wins so the event is not lost.
    wire               lost_nxt    = link_loss_evt || (status_r.link_lost && !err_reset);

    // RULE6 RULE7 self-test fault.
    wire               st_clear    = link_loss_evt || selftest_restart || err_reset;
    wire               st_nxt      = st_crc_set || (status_r.selftest_crc_fault && !st_clear);

    // RULE9 RULE10 remote fault.
    wire               rem_clear   = link_loss_evt || err_reset;
    wire               rem_nxt     = rem_crc_set || (status_r.remote_crc_fault && !rem_clear);

    wire [IRQ_W-1:0]   int_events  = {rem_crc_set, st_crc_set, link_loss_evt};
    wire [IRQ_W-1:0]   int_w1c     = wr_int_stat ? wdata_r[IRQ_W-1:0] : {IRQ_W{1'b0}};
    wire [IRQ_W-1:0]   int_stat_nxt = int_events | (int_stat_r & ~int_w1c);

    // RULE1 alias match.
    wire               alias_match = i2c_req.valid && (i2c_req.addr == alias_r);
    // RULE2 alias zero block.
    // A zero target address is treated as disabled as well, so no request is rewritten to address zero.
    wire               alias_open  = (alias_r != 7'h00) && (target_r != 7'h00);
    wire               fwd_hit     = alias_match && alias_open;
    wire               fwd_block   = i2c_req.valid && !alias_open &&
                                     ((alias_r == 7'h00) || alias_match);

    wire [7:0]         status_byte = {3'h0, status_r};
    wire [7:0]         rd_byte     =
        (ar_idx == IDX_TARGET)   ? {target_r, 1'b0} :
        (ar_idx == IDX_ALIAS)    ? {alias_r, 1'b0} :
        (ar_idx == IDX_CRC_LO)   ? crc_cnt_r[7:0] :
        (ar_idx == IDX_CRC_HI)   ? crc_cnt_r[15:8] :
        (ar_idx == IDX_STATUS)   ? status_byte :
        (ar_idx == IDX_INT_STAT) ? {5'h00, int_stat_r} :
        (ar_idx == IDX_INT_MASK) ? {5'h00, int_mask_r} : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_sync_r <= 2'h0;
            clk_sync_r  <= 2'h0;
        end else begin
            link_sync_r <= {link_sync_r[0], link_detect_pin};
            clk_sync_r  <= {clk_sync_r[0], input_clock_present_pin};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            awready_r <= !aw_held_nxt;
            wready_r  <= !w_held_nxt;
            bvalid_r  <= bvalid_nxt;
            if (wr_fire) begin
                bresp_r <= wr_mapped ? RESP_OKAY : RESP_DECERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_idx_r <= 6'h00;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_idx_r <= reg_index(s_axi_awaddr);
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= RESP_OKAY;
        end else begin
            arready_r <= !rvalid_nxt;
            rvalid_r  <= rvalid_nxt;
            if (ar_take) begin
                rdata_r <= {24'h000000, rd_byte};
                rresp_r <= rd_mapped ? RESP_OKAY : RESP_DECERR;
            end
        end
    end

    // RULE12 writable fields only.
    // Only the alias, target and interrupt registers take writes; other bits keep hardware values.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alias_r    <= ALIAS_RESET;
            target_r   <= TARGET_RESET;
            int_mask_r <= MASK_RESET;
        end else begin
            if (wr_alias) begin
                alias_r <= wdata_r[7:1];
            end
            if (wr_target) begin
                target_r <= wdata_r[7:1];
            end
            if (wr_int_mask) begin
                int_mask_r <= wdata_r[IRQ_W-1:0];
            end
        end
    end

    // Counter and status update
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crc_cnt_r  <= CRC_RESET;
            status_r   <= '0;
            int_stat_r <= '0;
            irq_r      <= 1'b0;
        end else begin
            crc_cnt_r                    <= crc_cnt_nxt;
            status_r.link_lost           <= lost_nxt;
            status_r.selftest_crc_fault  <= st_nxt;
            status_r.remote_crc_fault    <= rem_nxt;
            // RULE8 live clock presence.
            status_r.input_clock_present <= clk_now;
            // RULE11 live link detect.
            status_r.link_detect         <= link_now;
            int_stat_r                   <= int_stat_nxt;
            irq_r                        <= |(int_stat_nxt & int_mask_r);
        end
    end

    // RULE1 forwarding decision.
    // The decision is registered, so the forwarded address lags the request by one cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwd_r <= '0;
        end else begin
            fwd_r.valid   <= i2c_req.valid;
            fwd_r.hit     <= fwd_hit;
            fwd_r.blocked <= fwd_block;
            fwd_r.addr    <= fwd_hit ? target_r : i2c_req.addr;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign i2c_fwd       = fwd_r;
    assign irq           = irq_r;

endmodule

/* logic/lsa_pkg.sv */
// Package with the register map, field positions and carrier types of the link status block.
// Behaviour
// (RULE1) Hold a 7-bit alias; traffic to it is rewritten to the stored target address; the code blocks it instead while the target is zero.
// (RULE2) An alias field of zero blocks all access to the remote target.
// (RULE3) Count back-channel CRC errors in 16 read-only bits, low and high byte.
// (RULE4) The error-reset control clears both counter bytes.
// (RULE5) Loss of link sets status bit 4, held until the error-reset control.
// (RULE6) CRC errors during self-test set status bit 3.
// (RULE7) Link loss, self-test restart or error-reset clear status bit 3.
// (RULE8) Status bit 2 shows whether a valid input pixel clock is present.
// (RULE9) CRC errors during normal traffic set status bit 1.
// (RULE10) Link loss or error-reset clear status bit 1.
// (RULE11) Status bit 0 shows whether the cable link is detected.
// (RULE12) Software writes to counter, status and reserved bits are ignored.
package lsa_pkg;

    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0]  IDX_TARGET     = 6'h07;
    localparam logic [5:0]  IDX_ALIAS      = 6'h08;
    localparam logic [5:0]  IDX_CRC_LO     = 6'h0a;
    localparam logic [5:0]  IDX_CRC_HI     = 6'h0b;
    localparam logic [5:0]  IDX_STATUS     = 6'h0c;
    localparam logic [5:0]  IDX_INT_STAT   = 6'h10;
    localparam logic [5:0]  IDX_INT_MASK   = 6'h11;

    // Fields of the general status register.
    localparam int          ST_LINK_DET    = 0;
    localparam int          ST_REMOTE_CRC  = 1;
    localparam int          ST_CLK_PRESENT = 2;
    localparam int          ST_SELFTEST    = 3;
    localparam int          ST_LINK_LOST   = 4;

    // Fields of the interrupt status and mask registers.
    localparam int          IRQ_LINK_LOST  = 0;
    localparam int          IRQ_SELFTEST   = 1;
    localparam int          IRQ_REMOTE_CRC = 2;
    localparam int          IRQ_W          = 3;

    localparam logic [6:0]  ALIAS_RESET    = 7'h00;
    localparam logic [6:0]  TARGET_RESET   = 7'h00;
    localparam logic [15:0] CRC_RESET      = 16'h0000;
    localparam logic [15:0] CRC_MAX        = 16'hffff;
    localparam logic [2:0]  MASK_RESET     = 3'h0;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_DECERR    = 2'h3;

    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
    } lsa_i2c_req_t;

    typedef struct packed {
        logic       valid;
        logic       hit;
        logic       blocked;
        logic [6:0] addr;
    } lsa_i2c_fwd_t;

    typedef struct packed {
        logic link_lost;
        logic selftest_crc_fault;
        logic input_clock_present;
        logic remote_crc_fault;
        logic link_detect;
    } lsa_status_t;

endpackage

/* dv/lsa_link_model.sv */
// Far-end link model that raises CRC error and link loss events.
`timescale 1ns/1ps
module lsa_link_model (
    input  wire logic       aclk,
    input  wire logic       burst_go,
    input  wire logic [8:0] burst_len,
    input  wire logic       link_up,
    output logic            crc_err_evt,
    output logic            link_loss_evt,
    output logic            link_detect_pin
);
    logic [8:0] left_r = 9'h000;
    logic       up_r   = 1'b0;
    always_ff @(posedge aclk) begin
        left_r <= burst_go ? burst_len : left_r - {8'h00, left_r != 9'h000};
        up_r   <= link_up;
    end
    assign crc_err_evt     = left_r != 9'h000;
    assign link_loss_evt   = up_r & ~link_up;
    assign link_detect_pin = link_up;
endmodule

/* dv/lsa_top_properties.sv */
// Concurrent checks on the register bus and alias path of the link status block.
`timescale 1ns/1ps
module lsa_top_properties
    import lsa_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire lsa_i2c_req_t      i2c_req,
    input wire lsa_i2c_fwd_t      i2c_fwd
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during read answer");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !s_axi_bvalid |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    fwd_answer_a: assert property (i2c_req.valid |=> i2c_fwd.valid)
        else $error("alias decision missing");
    fwd_idle_a: assert property (!i2c_req.valid |=> !i2c_fwd.valid)
        else $error("alias decision without request");
    fwd_excl_a: assert property (i2c_fwd.blocked |-> i2c_fwd.valid && !i2c_fwd.hit)
        else $error("blocked request also mapped");
    fwd_pass_a: assert property (i2c_fwd.valid && !i2c_fwd.hit && !i2c_fwd.blocked
        |-> i2c_fwd.addr == $past(i2c_req.addr))
        else $error("foreign address altered");
endmodule
bind lsa_top lsa_top_properties lsa_props_u (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .i2c_req       (i2c_req),
    .i2c_fwd       (i2c_fwd)
);

/* dv/lsa_top_tb_top.sv */
// Self-checking bench for the link status block.
`timescale 1ns/1ps
module lsa_top_tb_top;
    import lsa_pkg::*;
    localparam logic [7:0] A_TG = {IDX_TARGET, 2'b00};
    localparam logic [7:0] A_AL = {IDX_ALIAS, 2'b00};
    localparam logic [7:0] A_LO = {IDX_CRC_LO, 2'b00};
    localparam logic [7:0] A_HI = {IDX_CRC_HI, 2'b00};
    localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};
    localparam logic [7:0] A_IS = {IDX_INT_STAT, 2'b00};
    localparam logic [7:0] A_IM = {IDX_INT_MASK, 2'b00};
    localparam int LD = 1 << ST_LINK_DET;
    localparam int RC = 1 << ST_REMOTE_CRC;
    localparam int CP = 1 << ST_CLK_PRESENT;
    localparam int SC = 1 << ST_SELFTEST;
    localparam int LL = 1 << ST_LINK_LOST;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic selftest_active, selftest_restart, err_reset, input_clock_present_pin;
    logic burst_go, link_up, crc_err_evt, link_loss_evt, link_detect_pin, irq;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic [7:0]        s_axi_awaddr, s_axi_araddr;
    logic [8:0]        burst_len;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    lsa_i2c_req_t      i2c_req;
    lsa_i2c_fwd_t      i2c_fwd;
    int                miscompares = 0;
    int                cmp_count = 0;
    lsa_top dut_u (
        .aclk                    (aclk),
        .aresetn                 (aresetn),
        .s_axi_awaddr            (s_axi_awaddr),
        .s_axi_awvalid           (s_axi_awvalid),
        .s_axi_awready           (s_axi_awready),
        .s_axi_wdata             (s_axi_wdata),
        .s_axi_wstrb             (s_axi_wstrb),
        .s_axi_wvalid            (s_axi_wvalid),
        .s_axi_wready            (s_axi_wready),
        .s_axi_bresp             (s_axi_bresp),
        .s_axi_bvalid            (s_axi_bvalid),
        .s_axi_bready            (s_axi_bready),
        .s_axi_araddr            (s_axi_araddr),
        .s_axi_arvalid           (s_axi_arvalid),
        .s_axi_arready           (s_axi_arready),
        .s_axi_rdata             (s_axi_rdata),
        .s_axi_rresp             (s_axi_rresp),
        .s_axi_rvalid            (s_axi_rvalid),
        .s_axi_rready            (s_axi_rready),
        .link_detect_pin         (link_detect_pin),
        .input_clock_present_pin (input_clock_present_pin),
        .link_loss_evt           (link_loss_evt),
        .crc_err_evt             (crc_err_evt),
        .selftest_active         (selftest_active),
        .selftest_restart        (selftest_restart),
        .err_reset               (err_reset),
        .i2c_req                 (i2c_req),
        .i2c_fwd                 (i2c_fwd),
        .irq                     (irq)
    );
    lsa_link_model link_u (
        .aclk            (aclk),
        .burst_go        (burst_go),
        .burst_len       (burst_len),
        .link_up         (link_up),
        .crc_err_evt     (crc_err_evt),
        .link_loss_evt   (link_loss_evt),
        .link_detect_pin (link_detect_pin)
    );
    initial forever #12.5 aclk = ~aclk;
    task automatic report_and_stop;
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 50) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
                break;
        end
        s_axi_bready <= 1'b0;
        tmo(n);
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
                break;
        end
        s_axi_rready <= 1'b0;
        tmo(n);
        chk("rdata", e, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
    endtask
    task automatic i2c(input logic [6:0] a, input logic [9:0] e, input logic [9:0] m);
        @(posedge aclk);
        i2c_req <= {1'b1, a};
        @(posedge aclk);
        i2c_req <= '0;
        @(posedge aclk);
        chk("i2c_fwd", 32'(e), 32'(i2c_fwd & m));
    endtask
    task automatic burst(input logic [8:0] n);
        @(posedge aclk);
        burst_go <= 1'b1;
        burst_len <= n;
        @(posedge aclk);
        burst_go <= 1'b0;
        repeat (n + 4) @(posedge aclk);
    endtask
    task automatic clr;
        @(posedge aclk);
        err_reset <= 1'b1;
        @(posedge aclk);
        err_reset <= 1'b0;
    endtask
    task automatic t_reset;
        logic [7:0] ra [7] = '{A_TG, A_AL, A_LO, A_HI, A_ST, A_IS, A_IM};
        foreach (ra[i])
            rd(ra[i], 0, RESP_OKAY);
        rd(8'h3c, 0, RESP_DECERR);
        wr(8'h3c, 32'hff, RESP_DECERR);
    endtask
    task automatic t_alias;
        i2c(7'h11, 10'h280, 10'h380);
        wr(A_AL, 32'h23, RESP_OKAY);
        rd(A_AL, 32'h22, RESP_OKAY);
        i2c(7'h11, 10'h280, 10'h380);
        wr(A_TG, 32'h54, RESP_OKAY);
        i2c(7'h11, 10'h32a, 10'h3ff);
        i2c(7'h12, 10'h212, 10'h3ff);
        s_axi_wstrb <= 4'he;
        wr(A_AL, 32'h00, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(A_AL, 32'h22, RESP_OKAY);
        wr(A_AL, 32'h00, RESP_OKAY);
        i2c(7'h11, 10'h280, 10'h380);
    endtask
    task automatic t_crc;
        burst(9'd260);
        rd(A_LO, 32'h04, RESP_OKAY);
        rd(A_HI, 32'h01, RESP_OKAY);
        rd(A_ST, RC, RESP_OKAY);
        wr(A_LO, 32'h00, RESP_OKAY);
        wr(A_ST, 32'hff, RESP_OKAY);
        rd(A_LO, 32'h04, RESP_OKAY);
        rd(A_ST, RC, RESP_OKAY);
        clr();
        rd(A_LO, 0, RESP_OKAY);
        rd(A_HI, 0, RESP_OKAY);
        rd(A_ST, 0, RESP_OKAY);
    endtask
    task automatic t_selftest;
        @(posedge aclk);
        selftest_active <= 1'b1;
        burst(9'd2);
        rd(A_ST, SC, RESP_OKAY);
        selftest_restart <= 1'b1;
        @(posedge aclk);
        selftest_restart <= 1'b0;
        rd(A_ST, 0, RESP_OKAY);
        burst(9'd1);
        rd(A_ST, SC, RESP_OKAY);
        clr();
        rd(A_ST, 0, RESP_OKAY);
        selftest_active <= 1'b0;
    endtask
    task automatic t_link;
        input_clock_present_pin <= 1'b1;
        link_up <= 1'b1;
        repeat (6) @(posedge aclk);
        rd(A_ST, LD | CP, RESP_OKAY);
        wr(A_IS, 32'h07, RESP_OKAY);
        wr(A_IM, 1 << IRQ_LINK_LOST, RESP_OKAY);
        burst(9'd1);
        chk("irq", 0, irq);
        rd(A_ST, LD | CP | RC, RESP_OKAY);
        selftest_active <= 1'b1;
        burst(9'd1);
        selftest_active <= 1'b0;
        rd(A_ST, LD | CP | RC | SC, RESP_OKAY);
        link_up <= 1'b0;
        repeat (6) @(posedge aclk);
        chk("irq", 1, irq);
        rd(A_ST, LL | CP, RESP_OKAY);
        link_up <= 1'b1;
        repeat (6) @(posedge aclk);
        rd(A_ST, LL | CP | LD, RESP_OKAY);
        wr(A_IS, 1 << IRQ_LINK_LOST, RESP_OKAY);
        chk("irq", 0, irq);
        rd(A_IS, (1 << IRQ_REMOTE_CRC) | (1 << IRQ_SELFTEST), RESP_OKAY);
        clr();
        input_clock_present_pin <= 1'b0;
        repeat (6) @(posedge aclk);
        rd(A_ST, LD, RESP_OKAY);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {selftest_active, selftest_restart, err_reset, input_clock_present_pin} = '0;
        {burst_go, link_up, burst_len, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        i2c_req = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_alias();
        t_crc();
        t_selftest();
        t_link();
        report_and_stop();
    end
endmodule
